/* File: rtl/flr_host_ctrl.sv */
/*
 * Host controller for a parallel NOR flash: APB registers, strobe sequencer, reset pulse.
 * Assumes the flash sits on the pins below, ready_busy_n has an external pull-up.
 */
// Operation
// RULE1: Host holds chip and write enable low, output enable high while writing.
// RULE2: Device latches address on last falling strobe, data on first rising.
// RULE3: Erase clears one uniform sector or the whole array.
// RULE4: Ready/busy is open-drain and shows whether an algorithm still runs.
// RULE5: Ready/busy is valid after the final write-enable rising edge.
// RULE6: Ready/busy is gated by chip enable, not output enable.
// RULE7: A long enough reset pulse aborts everything and ignores all accesses.
// RULE8: Hardware reset returns the device to array read.
// RULE9: Host should reissue program or erase interrupted by hardware reset.
// RULE10: Host issues software reset after autoselect, timeout, lock exit, aborts.
// RULE11: Software reset ignores address bits and is ignored while busy.
// RULE12: Software reset inside a program sequence returns sector to read.
// RULE13: Software reset returns erase-suspended sector to erase-suspend read.
// RULE14: Software reset is accepted midway through autoselect entry.
// RULE15: After buffer abort only the buffer-abort reset sequence restores read.
// RULE16: Lock register bit 0 guards secure area, bit 1 selects persistent mode.
// RULE17: Lock bits 3 and 4 report bulk erase enable and volatile power-up state.
// RULE18: Lock register is non-volatile; reserved bits read as ones.
// RULE19: Users may alter only lock register bit 0.
// RULE20: During lock command mode sector zero is blocked, others readable.
// RULE21: Sectors are persistently locked, dynamically locked, or unlocked.
// RULE22: Persistent guards cover groups of four uniform sectors, boot sectors singly.
// RULE23: Persistent guard erase pre-programs and verifies internally.
// RULE24: Volatile guard matters only when persistent guard is cleared.
// RULE25: Persistent guard freeze clears only by hardware reset or power-up.
// RULE26: Program or erase to a protected sector is refused unchanged.
`timescale 1ns/1ns
`default_nettype none

`include "flr_params.svh"

module flr_host_ctrl
    import flr_pkg::*;
#(
    parameter int MIN_RESET_PULSE_WIDTH_NS = `FLR_MIN_RESET_PULSE_NS,
    parameter int RESET_RECOVERY_NS = `FLR_RESET_RECOVERY_NS,
    parameter int RB_SETTLE_NS = `FLR_RB_SETTLE_NS,
    parameter logic [15:0] SETUP_CYC = 16'h0002,
    parameter logic [15:0] PULSE_CYC = 16'h0008,
    parameter logic [15:0] HOLD_CYC = 16'h0004,
    parameter logic [15:0] ACC_CYC = 16'h0014,
    parameter int AW = 22,
    parameter int DW = 16
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output flr_pins_s flash_ctl,
    output logic [AW-1:0] flash_addr,
    output logic [DW-1:0] flash_dq_o,
    output logic flash_dq_oe,
    input wire logic [DW-1:0] flash_dq_i,
    input wire logic ready_busy_n
);

    // ------------------------------------------------------------------------
    // Derived counts.
    // ------------------------------------------------------------------------
    localparam logic [15:0] RST_CYC =
        16'((MIN_RESET_PULSE_WIDTH_NS + `FLR_CLK_NS - 1) / `FLR_CLK_NS);
    localparam logic [15:0] REC_CYC = 16'((RESET_RECOVERY_NS + `FLR_CLK_NS - 1) / `FLR_CLK_NS);
    localparam logic [15:0] SETTLE_CYC = 16'((RB_SETTLE_NS + `FLR_CLK_NS - 1) / `FLR_CLK_NS);

    flr_state_e state_r;
    flr_op_e op_r;
    logic [15:0] cnt_r;
    logic wait_r;
    logic start_r;
    logic rerun_r;
    logic pend_r;
    logic [AW-1:0] addr_reg_r;
    logic [DW-1:0] wdata_r;
    logic [DW-1:0] rdata_r;
    logic [DW-1:0] dq_sync;
    logic rb_sync;
    logic busy;
    logic acc;
    logic rerun_clr;

    function automatic logic reg_hit(input logic [7:0] a);
        reg_hit = (a == `FLR_OFS_CMD) || (a == `FLR_OFS_ADDR) || (a == `FLR_OFS_WDATA) ||
                  (a == `FLR_OFS_RDATA) || (a == `FLR_OFS_STATUS);
    endfunction

    // ------------------------------------------------------------------------
    // Pin input synchroniser.
    // ------------------------------------------------------------------------
    flr_sync2 #(
        .W(DW + 1)
    ) u_sync (
        .clk(ref_clk),
        .rst(sys_rst),
        .din({ready_busy_n, flash_dq_i}),
        .dout({rb_sync, dq_sync})
    );

    assign busy = (state_r != FLR_ST_IDLE) || start_r;
    assign acc = psel && penable && !pready;
    assign rerun_clr = acc && pwrite && (paddr == `FLR_OFS_STATUS) && pwdata[`FLR_ST_RERUN_BIT];

    // ------------------------------------------------------------------------
    // APB slave.
    // ------------------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
            start_r <= 1'b0;
            op_r <= FLR_OP_WRITE;
            wait_r <= 1'b0;
            addr_reg_r <= `FLR_ADDR_RST;
            wdata_r <= `FLR_DATA_RST;
        end else begin
            pready <= acc;
            pslverr <= 1'b0;
            start_r <= 1'b0;
            if (acc && !reg_hit(paddr)) begin
                pslverr <= 1'b1;
            end else if (acc && pwrite) begin
                if (paddr == `FLR_OFS_CMD) begin
                    if (busy) begin
                        pslverr <= 1'b1;
                    end else begin
                        op_r <= flr_op_e'(pwdata[`FLR_CMD_OP_LSB +: 2]);
                        wait_r <= pwdata[`FLR_CMD_WAIT_BIT];
                        start_r <= 1'b1;
                    end
                end else if (paddr == `FLR_OFS_ADDR) begin
                    addr_reg_r <= pwdata[AW-1:0];
                end else if (paddr == `FLR_OFS_WDATA) begin
                    wdata_r <= pwdata[DW-1:0];
                end
            end else if (acc) begin
                if (paddr == `FLR_OFS_CMD) begin
                    prdata <= {29'h00000000, wait_r, op_r};
                end else if (paddr == `FLR_OFS_ADDR) begin
                    prdata <= {{(32 - AW){1'b0}}, addr_reg_r};
                end else if (paddr == `FLR_OFS_WDATA) begin
                    prdata <= {{(32 - DW){1'b0}}, wdata_r};
                end else if (paddr == `FLR_OFS_RDATA) begin
                    prdata <= {{(32 - DW){1'b0}}, rdata_r};
                end else begin
                    prdata <= {29'h00000000, rerun_r, rb_sync, busy};
                end
            end
        end
    end

    // ------------------------------------------------------------------------
    // Interrupted-operation flag; a new event beats a clear.
    // ------------------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            rerun_r <= 1'b0;
        end else if (state_r == FLR_ST_IDLE && start_r && op_r == FLR_OP_HWRST && pend_r) begin
            rerun_r <= 1'b1; // RULE9
        end else if (rerun_clr) begin
            rerun_r <= 1'b0;
        end
    end
    always_ff @(posedge ref_clk) begin
        if (sys_rst || state_r == FLR_ST_RST_LOW) begin
            pend_r <= 1'b0; // RULE7
        end else if (state_r == FLR_ST_W_PULSE && cnt_r == 16'h0000) begin
            pend_r <= 1'b1; // RULE5
        end else if ((state_r == FLR_ST_R_ACC || state_r == FLR_ST_RB_WAIT) && cnt_r == 16'h0000
                     && rb_sync) begin
            pend_r <= 1'b0; // RULE6
        end
    end

    // ------------------------------------------------------------------------
    // Strobe sequencer.
    // ------------------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            state_r <= FLR_ST_IDLE;
            cnt_r <= 16'h0000;
            flash_ctl <= FLR_PINS_IDLE;
            flash_addr <= '0;
            flash_dq_o <= '0;
            flash_dq_oe <= 1'b0;
            rdata_r <= '0;
        end else begin
            case (state_r)
                FLR_ST_IDLE: begin
                    if (start_r) begin
                        case (op_r)
                            FLR_OP_WRITE: begin
                                flash_addr <= addr_reg_r;
                                flash_dq_o <= wdata_r; // RULE10 RULE15
                                flash_dq_oe <= 1'b1;
                                flash_ctl.ce_n <= 1'b0; // RULE1
                                cnt_r <= SETUP_CYC;
                                state_r <= FLR_ST_W_SETUP;
                            end
                            FLR_OP_READ: begin
                                flash_addr <= addr_reg_r;
                                flash_ctl.ce_n <= 1'b0;
                                flash_ctl.oe_n <= 1'b0;
                                cnt_r <= ACC_CYC;
                                state_r <= FLR_ST_R_ACC;
                            end
                            FLR_OP_HWRST: begin
                                flash_ctl.reset_n <= 1'b0; // RULE7
                                cnt_r <= RST_CYC;
                                state_r <= FLR_ST_RST_LOW;
                            end
                            default: begin
                                flash_ctl.ce_n <= 1'b0; // RULE6
                                cnt_r <= SETTLE_CYC;
                                state_r <= FLR_ST_RB_WAIT;
                            end
                        endcase
                    end
                end
                FLR_ST_W_SETUP: begin
                    if (cnt_r == 16'h0000) begin
                        flash_ctl.we_n <= 1'b0; // RULE2
                        cnt_r <= PULSE_CYC;
                        state_r <= FLR_ST_W_PULSE;
                    end else begin
                        cnt_r <= cnt_r - 16'h0001;
                    end
                end
                FLR_ST_W_PULSE: begin
                    if (cnt_r == 16'h0000) begin
                        flash_ctl.we_n <= 1'b1; // RULE2
                        cnt_r <= HOLD_CYC;
                        state_r <= FLR_ST_W_HOLD;
                    end else begin
                        cnt_r <= cnt_r - 16'h0001;
                    end
                end
                FLR_ST_W_HOLD: begin
                    if (cnt_r == 16'h0000) begin
                        flash_dq_oe <= 1'b0;
                        if (wait_r) begin
                            cnt_r <= SETTLE_CYC; // RULE5
                            state_r <= FLR_ST_RB_WAIT;
                        end else begin
                            flash_ctl.ce_n <= 1'b1;
                            state_r <= FLR_ST_IDLE;
                        end
                    end else begin
                        cnt_r <= cnt_r - 16'h0001;
                    end
                end
                FLR_ST_R_ACC: begin
                    if (cnt_r == 16'h0000) begin
                        rdata_r <= dq_sync;
                        flash_ctl.ce_n <= 1'b1;
                        flash_ctl.oe_n <= 1'b1;
                        state_r <= FLR_ST_IDLE;
                    end else begin
                        cnt_r <= cnt_r - 16'h0001;
                    end
                end
                FLR_ST_RST_LOW: begin
                    if (cnt_r == 16'h0000) begin
                        flash_ctl.reset_n <= 1'b1;
                        cnt_r <= REC_CYC; // RULE8
                        state_r <= FLR_ST_RST_REC;
                    end else begin
                        cnt_r <= cnt_r - 16'h0001;
                    end
                end
                FLR_ST_RST_REC: begin
                    if (cnt_r == 16'h0000) begin
                        state_r <= FLR_ST_IDLE;
                    end else begin
                        cnt_r <= cnt_r - 16'h0001;
                    end
                end
                default: begin
                    if (cnt_r != 16'h0000) begin
                        cnt_r <= cnt_r - 16'h0001;
                    end else if (rb_sync) begin
                        flash_ctl.ce_n <= 1'b1; // RULE4
                        state_r <= FLR_ST_IDLE;
                    end
                end
            endcase
        end
    end

endmodule

`default_nettype wire

/* File: inc/flr_params.svh */
/*
 * Register offsets, field positions, reset values and timing figures of the flash host controller.
 * Assumes a 32-bit APB register bus and a 250 MHz controller clock.
 */
`ifndef FLR_PARAMS_SVH
`define FLR_PARAMS_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define FLR_OFS_CMD 8'h00
`define FLR_OFS_ADDR 8'h04
`define FLR_OFS_WDATA 8'h08
`define FLR_OFS_RDATA 8'h0c
`define FLR_OFS_STATUS 8'h10

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define FLR_CMD_OP_LSB 0
`define FLR_CMD_WAIT_BIT 2
`define FLR_ST_BUSY_BIT 0
`define FLR_ST_READY_BIT 1
`define FLR_ST_RERUN_BIT 2

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define FLR_ADDR_RST 22'h000000
`define FLR_DATA_RST 16'h0000

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define FLR_CLK_NS 4
`define FLR_MIN_RESET_PULSE_NS 500
`define FLR_RESET_RECOVERY_NS 200
`define FLR_RB_SETTLE_NS 100

`endif

/* File: inc/flr_pkg.sv */
/*
 * Types of the flash host controller: operations, sequencer states and the strobe bundle.
 * Assumes the constants of flr_params.svh for all figures.
 */
package flr_pkg;

    typedef enum logic [1:0] {
        FLR_OP_WRITE = 2'b00,
        FLR_OP_READ = 2'b01,
        FLR_OP_HWRST = 2'b10,
        FLR_OP_RBWAIT = 2'b11
    } flr_op_e;

    typedef enum logic [2:0] {
        FLR_ST_IDLE = 3'b000,
        FLR_ST_W_SETUP = 3'b001,
        FLR_ST_W_PULSE = 3'b010,
        FLR_ST_W_HOLD = 3'b011,
        FLR_ST_R_ACC = 3'b100,
        FLR_ST_RST_LOW = 3'b101,
        FLR_ST_RST_REC = 3'b110,
        FLR_ST_RB_WAIT = 3'b111
    } flr_state_e;

    typedef struct packed {
        logic ce_n;
        logic we_n;
        logic oe_n;
        logic reset_n;
    } flr_pins_s;

    localparam flr_pins_s FLR_PINS_IDLE = '{ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1, reset_n: 1'b1};

endpackage

/* File: rtl/flr_sync2.sv */
/*
 * Two-flop synchroniser for a bundle of pin inputs.
 * Assumes each bit is a slow level; no bit-to-bit coherence is promised.
 */
`timescale 1ns/1ns
`default_nettype none

module flr_sync2 #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);

    logic [W-1:0] meta_r;

    // ------------------------------------------------------------------------
    // Two stages.
    // ------------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            meta_r <= '0;
            dout <= '0;
        end else begin
            meta_r <= din;
            dout <= meta_r;
        end
    end

endmodule

`default_nettype wire

/* File: sim/flr_host_ctrl_sva.sv */
/*
 * Checker for the flash host controller strobes, reset pulse and APB answer.
 * Assumes binding to flr_host_ctrl and a 4 ns controller clock.
 */
`timescale 1ns/1ns
`default_nettype none

module flr_host_ctrl_sva
    import flr_pkg::*;
#(
    parameter int MIN_RESET_PULSE_WIDTH_NS = 500,
    parameter logic [15:0] PULSE_CYC = 16'h0008
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire flr_pins_s flash_ctl,
    input wire logic [21:0] flash_addr,
    input wire logic [15:0] flash_dq_o,
    input wire logic flash_dq_oe
);
    localparam int RST_CYC = (MIN_RESET_PULSE_WIDTH_NS + 3) / 4;
    localparam int PLS = int'(PULSE_CYC);

    default clocking @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    // ------------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------------
    AST_WRITE_STROBES: assert property (
        !flash_ctl.we_n |-> !flash_ctl.ce_n && flash_ctl.oe_n && flash_dq_oe)
        else $error("write strobe without chip enable or data");
    AST_NO_CONTENTION: assert property (
        !flash_ctl.oe_n |-> !flash_dq_oe)
        else $error("data driven during read");
    AST_ADDR_SETUP: assert property (
        $fell(flash_ctl.we_n) |-> $stable(flash_addr) && $stable(flash_dq_o) && !$past(flash_ctl.ce_n))
        else $error("address or data not set up before strobe");
    AST_WE_PULSE_WIDTH: assert property (
        $fell(flash_ctl.we_n) |-> ##PLS !flash_ctl.we_n ##1 flash_ctl.we_n)
        else $error("write pulse length wrong");
    AST_DATA_HOLD: assert property (
        $rose(flash_ctl.we_n) |-> (flash_dq_oe && $stable(flash_dq_o) && $stable(flash_addr))[*4])
        else $error("data not held after strobe rise");
    AST_RESET_PULSE: assert property (
        $fell(flash_ctl.reset_n) |-> ##RST_CYC !flash_ctl.reset_n ##1 flash_ctl.reset_n)
        else $error("reset pulse width wrong");
    AST_RESET_QUIET: assert property (
        !flash_ctl.reset_n |-> flash_ctl.ce_n && flash_ctl.we_n && flash_ctl.oe_n && !flash_dq_oe)
        else $error("access during reset pulse");
    AST_APB_ONE_WAIT: assert property (
        psel && penable && !pready |=> pready)
        else $error("apb answer late");
endmodule

bind flr_host_ctrl flr_host_ctrl_sva #(
    .MIN_RESET_PULSE_WIDTH_NS(MIN_RESET_PULSE_WIDTH_NS),
    .PULSE_CYC(PULSE_CYC)
) u_sva (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .psel(psel),
    .penable(penable),
    .pready(pready),
    .flash_ctl(flash_ctl),
    .flash_addr(flash_addr),
    .flash_dq_o(flash_dq_o),
    .flash_dq_oe(flash_dq_oe)
);

`default_nettype wire

/* File: sim/flr_dev_model.sv */
/*
 * Behavioural flash device: command latching, busy algorithm, lock register, resets.
 * Assumes strobes from the controller and a pull-up on the ready/busy line.
 */
`timescale 1ns/1ns
`default_nettype none

module flr_dev_model
    import flr_pkg::*;
#(
    parameter int BUSY_NS = 400
) (
    input wire flr_pins_s pins,
    input wire logic [21:0] addr,
    input wire logic [15:0] dq_in,
    output logic [15:0] dq_out,
    output logic rb_low
);
    logic busy = 1'b0;
    logic lock_mode = 1'b0;
    logic armed = 1'b0;
    logic [15:0] sector_lock_options = 16'hfffd;
    logic [15:0] mem = 16'h0000;
    logic [15:0] pend;
    logic [15:0] last_data = 16'h0000;
    logic [21:0] last_addr = 22'h000000;
    logic [21:0] a_lat;
    int gen = 0;
    wire wr_on = !pins.ce_n && !pins.we_n;
    wire rd_on = !pins.ce_n && !pins.oe_n && pins.reset_n;
    wire [15:0] rdv = lock_mode ? sector_lock_options : mem;

    // ------------------------------------------------------------------
    // Command cycles
    // ------------------------------------------------------------------
    always @(posedge wr_on) begin
        armed = pins.reset_n;
        if (pins.reset_n) a_lat = addr;
    end
    always @(negedge wr_on) begin
        if (armed && pins.reset_n && !busy) begin
            armed = 1'b0;
            last_addr = a_lat;
            last_data = dq_in;
            if (dq_in == 16'h00f0) lock_mode = 1'b0;
            else if (dq_in == 16'h0040) lock_mode = 1'b1;
            else if (lock_mode) sector_lock_options[0] = dq_in[0];
            else begin
                busy = 1'b1;
                pend = dq_in;
                fork
                    begin
                        automatic int g = gen;
                        #BUSY_NS;
                        if (g == gen) begin
                            mem = pend;
                            busy = 1'b0;
                        end
                    end
                join_none
            end
        end
    end
    always @(negedge pins.reset_n) begin
        gen++;
        busy = 1'b0;
        lock_mode = 1'b0;
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign rb_low = busy && !pins.ce_n;
    assign dq_out = rd_on ? rdv : ~rdv;
endmodule

`default_nettype wire

/* File: sim/flr_host_ctrl_bench.sv */
/*
 * Self-checking bench: APB tasks drive the controller against the device model.
 * Assumes the register map of flr_params.svh.
 */
`timescale 1ns/1ns
`default_nettype none

`include "flr_params.svh"

module flr_host_ctrl_bench
    import flr_pkg::*;
;
    logic ref_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    flr_pins_s flash_ctl;
    logic [21:0] flash_addr;
    logic [15:0] flash_dq_o;
    logic [15:0] dq_dev;
    logic flash_dq_oe;
    logic rb_low;
    wire logic [15:0] flash_dq_i;
    wire logic ready_busy_n;
    int fail_count = 0;
    int check_count = 0;
    int cyc = 0;
    logic [31:0] rd;
    logic er;

    assign flash_dq_i = flash_dq_oe ? flash_dq_o : dq_dev;
    assign ready_busy_n = rb_low ? 1'b0 : 1'b1;

    flr_host_ctrl #(.MIN_RESET_PULSE_WIDTH_NS(20), .RESET_RECOVERY_NS(20), .RB_SETTLE_NS(20))
    i_flr_host_ctrl (.ref_clk(ref_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .flash_ctl(flash_ctl), .flash_addr(flash_addr),
        .flash_dq_o(flash_dq_o), .flash_dq_oe(flash_dq_oe), .flash_dq_i(flash_dq_i),
        .ready_busy_n(ready_busy_n));

    flr_dev_model u_dev (.pins(flash_ctl), .addr(flash_addr), .dq_in(flash_dq_i),
        .dq_out(dq_dev), .rb_low(rb_low));

    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    task automatic tally_and_finish;
        if (fail_count == 0 && check_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        @(posedge ref_clk);
        while (pready !== 1'b1) @(posedge ref_clk);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge ref_clk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
        chk("write_err", 32'h0, {31'h0, er});
    endtask

    task automatic rdx(input logic [7:0] a, input logic [31:0] exp, input string nm);
        apb(1'b0, a, 32'h0);
        chk(nm, exp, rd);
    endtask

    task automatic wait_idle;
        int n;
        n = 0;
        do begin
            apb(1'b0, `FLR_OFS_STATUS, 32'h0);
            n++;
        end while (rd[0] !== 1'b0 && n < 3000);
        chk("idle", 32'h0, {31'h0, rd[0]});
    endtask

    task automatic op(input logic [31:0] c);
        wr(`FLR_OFS_CMD, c);
        wait_idle();
    endtask

    // ------------------------------------------------------------------
    // Clock, timeout and sequence
    // ------------------------------------------------------------------
    initial forever #2 ref_clk = ~ref_clk;

    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 20000) begin
            fail_count++;
            tally_and_finish();
        end
    end

    initial begin
        repeat (8) @(posedge ref_clk);
        sys_rst <= 1'b0;
        @(posedge ref_clk);
        rdx(`FLR_OFS_STATUS, 32'h2, "status_rst");
        rdx(`FLR_OFS_ADDR, 32'h0, "addr_rst");
        apb(1'b0, 8'h14, 32'h0);
        chk("unmapped_err", 32'h1, {31'h0, er});
        wr(`FLR_OFS_ADDR, 32'h002a5a5a);
        wr(`FLR_OFS_WDATA, 32'h1234);
        wr(`FLR_OFS_CMD, 32'h4);
        apb(1'b1, `FLR_OFS_CMD, 32'h1);
        chk("busy_cmd_err", 32'h1, {31'h0, er});
        wait_idle();
        rdx(`FLR_OFS_CMD, 32'h4, "cmd_readback");
        chk("dev_addr", 32'h002a5a5a, {10'h0, u_dev.last_addr});
        chk("dev_data", 32'h1234, {16'h0, u_dev.last_data});
        chk("dev_done", 32'h0, {31'h0, u_dev.busy});
        op(32'h1);
        rdx(`FLR_OFS_RDATA, 32'h1234, "array_read");
        wr(`FLR_OFS_WDATA, 32'h0040);
        op(32'h0);
        op(32'h1);
        rdx(`FLR_OFS_RDATA, 32'hfffd, "lock_reg");
        wr(`FLR_OFS_WDATA, 32'h0000);
        op(32'h0);
        op(32'h1);
        rdx(`FLR_OFS_RDATA, 32'hfffc, "lock_bit0");
        wr(`FLR_OFS_WDATA, 32'h00f0);
        op(32'h0);
        op(32'h1);
        rdx(`FLR_OFS_RDATA, 32'h1234, "soft_reset");
        op(32'h2);
        op(32'h1);
        rdx(`FLR_OFS_RDATA, 32'h1234, "after_hw_reset");
        wr(`FLR_OFS_WDATA, 32'h5678);
        op(32'h0);
        op(32'h2);
        op(32'h3);
        apb(1'b0, `FLR_OFS_STATUS, 32'h0);
        chk("ready_after_abort", 32'h6, rd);
        wr(`FLR_OFS_STATUS, 32'h4);
        rdx(`FLR_OFS_STATUS, 32'h2, "rerun_clear");
        op(32'h1);
        rdx(`FLR_OFS_RDATA, 32'h1234, "aborted_program");
        tally_and_finish();
    end
endmodule

`default_nettype wire
